/* File: design/dacicp_fifo.sv */
// Synchronous FIFO with valid and ready on both sides
`timescale 1ns/1ps
module dacicp_fifo #(
    parameter int W = 14,
    parameter int DEPTH = 8
) (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    dacicp_fifo_if.fifo f
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic [AW-1:0] next_wr_ptr;
    logic [AW-1:0] next_rd_ptr;
    logic [AW:0] next_count;
    logic push;
    logic pop;

    assign f.in_ready = (count != (AW+1)'(DEPTH));
    assign f.out_valid = (count != '0);
    assign f.out_data = mem[rd_ptr];
    assign push = f.in_valid && f.in_ready;
    assign pop = f.out_valid && f.out_ready;

    always_comb begin
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        next_count = count;
        if (push) begin
            next_wr_ptr = (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
        end
        if (pop) begin
            next_rd_ptr = (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
        end
        if (push && !pop) begin
            next_count = count + 1'b1;
        end else if (pop && !push) begin
            next_count = count - 1'b1;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (push) begin
            mem[wr_ptr] <= f.in_data;
        end
    end

    a_fifo_no_overflow: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        count <= (AW+1)'(DEPTH)) else $error("FIFO count above depth");
endmodule

/* File: design/dacicp_top.sv */
// Sample input capture path: capture, coding, deskew, clock mode and registers
//
// The register offsets and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
module dacicp_top
    import dacicp_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic [DATA_W-1:0] i_input_sample_word,
    input wire logic i_sample_valid,
    input wire logic i_clock_mode_strap,
    input wire logic i_serial_enable,
    input wire logic i_core_ready,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [REG_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [REG_W-1:0] o_rdata,
    output logic o_sample_ready,
    output logic [DATA_W-1:0] o_primary_code,
    output logic [DATA_W-1:0] o_complement_code,
    output logic o_code_valid,
    output logic o_diff_clock_select
);
    ////////////////////////////////////////////////////////////////////////////
    // Functions

    function automatic logic [DATA_W-1:0] res_mask(input logic [1:0] res);
        logic [DATA_W-1:0] m;
        m = '1;
        case (res)
            DACICP_RES_8: m = {6'h00, 8'hff};
            DACICP_RES_10: m = {4'h0, 10'h3ff};
            DACICP_RES_12: m = {2'h0, 12'hfff};
            default: m = '1;
        endcase
        return m;
    endfunction

    function automatic logic [DATA_W-1:0] res_msb(input logic [1:0] res);
        return ((res_mask(res) >> 1) + 1'b1) & res_mask(res);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    logic [DATA_W-1:0] word_s1;
    logic [DATA_W-1:0] word_s2;
    logic valid_s1;
    logic valid_s2;
    logic strap_s1;
    logic strap_s2;
    logic spi_s1;
    logic spi_s2;

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            word_s1 <= '0;
            word_s2 <= '0;
            valid_s1 <= 1'b0;
            valid_s2 <= 1'b0;
            strap_s1 <= 1'b0;
            strap_s2 <= 1'b0;
            spi_s1 <= 1'b0;
            spi_s2 <= 1'b0;
        end else begin
            word_s1 <= i_input_sample_word;
            word_s2 <= word_s1;
            valid_s1 <= i_sample_valid;
            valid_s2 <= valid_s1;
            strap_s1 <= i_clock_mode_strap;
            strap_s2 <= strap_s1;
            spi_s1 <= i_serial_enable;
            spi_s2 <= spi_s1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    logic [REG_W-1:0] data_cfg;
    logic [REG_W-1:0] coding;
    logic [1:0] resolution;
    logic [REG_W-1:0] rdata;
    logic [REG_W-1:0] next_data_cfg;
    logic [REG_W-1:0] next_coding;
    logic [1:0] next_resolution;
    logic [REG_W-1:0] next_rdata;
    logic overflow;
    logic next_overflow;
    logic fifo_level_ne;
    logic deskew_en;
    logic twos_en;
    logic diff_sel;

    assign deskew_en = data_cfg[BIT_DESKEW];
    assign twos_en = coding[BIT_TWOS];
    assign diff_sel = spi_s2 ? data_cfg[BIT_DIFF_CLOCK] : strap_s2;

    always_comb begin
        next_data_cfg = data_cfg;
        next_coding = coding;
        next_resolution = resolution;
        next_rdata = '0;
        if (i_wr) begin
            case (i_addr)
                REG_DATA_CFG: next_data_cfg = i_wdata & 8'h06;
                REG_CODING: next_coding = i_wdata & 8'h01;
                REG_RESOLUTION: next_resolution = i_wdata[1:0];
                default: next_data_cfg = data_cfg;
            endcase
        end
        if (i_rd) begin
            case (i_addr)
                REG_DATA_CFG: next_rdata = data_cfg;
                REG_CODING: next_rdata = coding;
                REG_RESOLUTION: next_rdata = {6'h00, resolution};
                REG_STATUS: next_rdata = {5'h00, fifo_level_ne, overflow, diff_sel};
                default: next_rdata = UNMAPPED_READ;
            endcase
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            data_cfg <= DATA_CFG_RST;
            coding <= CODING_RST;
            resolution <= RES_RST;
            rdata <= '0;
        end else begin
            data_cfg <= next_data_cfg;
            coding <= next_coding;
            resolution <= next_resolution;
            rdata <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Coding and deskew stage

    logic [DATA_W-1:0] coded;
    logic [DATA_W-1:0] deskew_word;
    logic deskew_valid;
    logic [DATA_W-1:0] next_deskew_word;
    logic next_deskew_valid;
    logic [DATA_W-1:0] path_word;
    logic path_valid;

    always_comb begin
        coded = word_s2 & res_mask(resolution);
        if (twos_en) begin
            coded = coded ^ res_msb(resolution);
        end
        next_deskew_word = coded;
        next_deskew_valid = valid_s2;
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            deskew_word <= '0;
            deskew_valid <= 1'b0;
        end else begin
            deskew_word <= next_deskew_word;
            deskew_valid <= next_deskew_valid;
        end
    end

    assign path_word = deskew_en ? deskew_word : coded;
    assign path_valid = deskew_en ? deskew_valid : valid_s2;

    ////////////////////////////////////////////////////////////////////////////
    // FIFO towards the converter core

    dacicp_fifo_if #(.W(DATA_W)) fq ();

    assign fq.in_data = path_word;
    assign fq.in_valid = path_valid;
    assign fq.out_ready = i_core_ready;
    assign fifo_level_ne = fq.out_valid;

    dacicp_fifo #(.W(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .f(fq.fifo)
    );

    always_comb begin
        next_overflow = overflow;
        if (path_valid && !fq.in_ready) begin
            next_overflow = 1'b1;
        end else if (i_wr && i_addr == REG_STATUS && i_wdata[1]) begin
            next_overflow = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output registers

    logic [DATA_W-1:0] primary;
    logic [DATA_W-1:0] complement;
    logic code_valid;
    logic ready_q;
    logic diff_q;
    logic [DATA_W-1:0] next_primary;
    logic [DATA_W-1:0] next_complement;
    logic next_code_valid;

    always_comb begin
        next_primary = primary;
        next_complement = complement;
        next_code_valid = 1'b0;
        if (fq.out_valid && i_core_ready) begin
            next_primary = fq.out_data;
            next_complement = res_mask(resolution) & ~fq.out_data;
            next_code_valid = 1'b1;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            primary <= '0;
            complement <= '0;
            code_valid <= 1'b0;
            overflow <= 1'b0;
            ready_q <= 1'b0;
            diff_q <= 1'b0;
        end else begin
            primary <= next_primary;
            complement <= next_complement;
            code_valid <= next_code_valid;
            overflow <= next_overflow;
            ready_q <= fq.in_ready;
            diff_q <= diff_sel;
        end
    end

    assign o_primary_code = primary;
    assign o_complement_code = complement;
    assign o_code_valid = code_valid;
    assign o_sample_ready = ready_q;
    assign o_diff_clock_select = diff_q;
    assign o_rdata = rdata;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    sequence s_dsk_in;
        valid_s2 && deskew_en;
    endsequence

    a_deskew_one_cycle: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        s_dsk_in ##1 deskew_en |-> path_valid && path_word == $past(coded))
        else $error("Deskew stage delay is not one cycle");
    a_bypass_direct: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        !deskew_en |-> path_word == coded) else $error("Bypass path not direct");
    a_deskew_reset: assert property (@(posedge i_mclk)
        !i_rst_n |=> !deskew_en) else $error("Deskew not cleared by reset");
    a_clock_mode_sel: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        ##1 o_diff_clock_select == $past(spi_s2 ? data_cfg[BIT_DIFF_CLOCK] : strap_s2))
        else $error("Clock mode source wrong");
    a_single_ended: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (spi_s2 && !data_cfg[BIT_DIFF_CLOCK]) ##1 (spi_s2 && !data_cfg[BIT_DIFF_CLOCK])
        |-> !o_diff_clock_select) else $error("Single-ended mode not selected");
    a_twos_msb: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        twos_en && resolution == DACICP_RES_14 |-> coded[DATA_W-1] != word_s2[DATA_W-1])
        else $error("Twos complement top bit not inverted");
    a_binary_pass: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        !twos_en && resolution == DACICP_RES_14 |-> coded == word_s2)
        else $error("Binary word altered");
    a_split_scale: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        o_code_valid |-> (o_primary_code ^ o_complement_code) == res_mask(resolution))
        else $error("Outputs do not split full scale");
    a_update_edge: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        fq.out_valid && i_core_ready |=> o_code_valid && o_primary_code == $past(fq.out_data))
        else $error("Output not updated on edge");
    a_width_mask: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (coded & ~res_mask(resolution)) == '0) else $error("Bits above width set");

    sequence s_reg_diff;
        spi_s2 && data_cfg[BIT_DIFF_CLOCK];
    endsequence

    sequence s_strap_diff;
        !spi_s2 && strap_s2;
    endsequence

    a_diff_register: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        s_reg_diff ##1 s_reg_diff |-> o_diff_clock_select)
        else $error("Differential mode not selected by register");
    a_diff_strap: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        s_strap_diff ##1 s_strap_diff |-> o_diff_clock_select)
        else $error("Differential mode not selected by strap");
    a_twos_all_res: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        twos_en |-> (coded ^ (word_s2 & res_mask(resolution))) == res_msb(resolution))
        else $error("Twos complement inversion wrong");
    a_split_disjoint: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        o_code_valid |-> (o_primary_code & o_complement_code) == '0)
        else $error("Outputs overlap");
    a_rdata_idle: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        !i_rd |=> o_rdata == '0) else $error("Read data outside read cycle");
    a_overflow_set: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        path_valid && !fq.in_ready |=> overflow) else $error("Dropped word not flagged");
endmodule

/* File: include/dacicp_fifo_if.sv */
// Interface carrying sample words between the capture path and its FIFO
`timescale 1ns/1ps
interface dacicp_fifo_if #(parameter int W = 14);
    logic [W-1:0] in_data;
    logic in_valid;
    logic in_ready;
    logic [W-1:0] out_data;
    logic out_valid;
    logic out_ready;
    modport fifo (input in_data, input in_valid, output in_ready,
                  output out_data, output out_valid, input out_ready);
    modport user (output in_data, output in_valid, input in_ready,
                  input out_data, input out_valid, output out_ready);
endinterface

/* File: include/dacicp_pkg.sv */
// Package for the sample input capture path: widths, offsets and reset values
// Functional notes
// - Sample input is 14 bits wide, smaller variants use 12, 10 or 8 low bits.
// - Input words are read as straight binary or twos complement.
// - All-ones code gives full scale; complement output carries the remainder.
// - Words captured on rising clock edge; output updates every edge; design updates it only with a FIFO word and i_core_ready high.
// - Capture works at any clock duty cycle; no duty cycle assumed.
// - Deskew mode adds exactly one register stage of delay to the data path.
// - Deskew enable sits in register 0x02 and resets to 0.
// - Clock mode comes from strap without serial interface, else register 0x02 bit 2.
// - Strap low or bit 0 selects the single-ended clock receiver.
// - Strap high or bit 1 selects the differential receiver.
package dacicp_pkg;
    localparam int DATA_W = 14;
    localparam int ADDR_W = 8;
    localparam int REG_W = 8;
    localparam int FIFO_DEPTH = 8;
    localparam logic [ADDR_W-1:0] REG_DATA_CFG = 8'h02;
    localparam logic [ADDR_W-1:0] REG_CODING = 8'h20;
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h21;
    localparam logic [ADDR_W-1:0] REG_RESOLUTION = 8'h22;
    localparam int BIT_DESKEW = 1;
    localparam int BIT_DIFF_CLOCK = 2;
    localparam int BIT_TWOS = 0;
    localparam logic [REG_W-1:0] DATA_CFG_RST = 8'h00;
    localparam logic [REG_W-1:0] CODING_RST = 8'h00;
    localparam logic [1:0] RES_RST = 2'h3;
    localparam logic [REG_W-1:0] UNMAPPED_READ = 8'h00;
    typedef enum logic [1:0] {
        DACICP_RES_8 = 2'h0,
        DACICP_RES_10 = 2'h1,
        DACICP_RES_12 = 2'h2,
        DACICP_RES_14 = 2'h3
    } dacicp_res_t;
endpackage

/* File: verification/dacicp_src_model.sv */
// Data source model driving parallel sample words
`timescale 1ns/1ps
module dacicp_src_model
    import dacicp_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_load,
    input wire logic [DATA_W-1:0] i_word,
    output logic [DATA_W-1:0] o_sample_word,
    output logic o_sample_valid
);
    initial begin
        o_sample_word = '0;
        o_sample_valid = 1'b0;
    end
    // Idle pins toggle so stale data never passes for new
    always @(negedge i_mclk) begin
        o_sample_valid <= i_load;
        o_sample_word <= i_load ? i_word : ~o_sample_word;
    end
endmodule

/* File: verification/tb_top.sv */
// Testbench for the sample input capture path
`timescale 1ns/1ps
module tb_top
    import dacicp_pkg::*;
;
    logic i_mclk, i_rst_n, i_sample_valid, i_clock_mode_strap, i_serial_enable;
    logic i_core_ready, i_wr, i_rd, o_sample_ready, o_code_valid, o_diff_clock_select, ld;
    logic [DATA_W-1:0] i_input_sample_word, o_primary_code, o_complement_code, wd;
    logic [ADDR_W-1:0] i_addr;
    logic [REG_W-1:0] i_wdata, o_rdata, rv;
    logic [31:0] seed;
    int fails, checks, lat, l0, n;

    dacicp_top dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
        .i_input_sample_word(i_input_sample_word), .i_sample_valid(i_sample_valid),
        .i_clock_mode_strap(i_clock_mode_strap), .i_serial_enable(i_serial_enable),
        .i_core_ready(i_core_ready), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
        .i_rd(i_rd), .o_rdata(o_rdata), .o_sample_ready(o_sample_ready),
        .o_primary_code(o_primary_code), .o_complement_code(o_complement_code),
        .o_code_valid(o_code_valid), .o_diff_clock_select(o_diff_clock_select));
    dacicp_src_model src (.i_mclk(i_mclk), .i_load(ld), .i_word(wd),
        .o_sample_word(i_input_sample_word), .o_sample_valid(i_sample_valid));

    always #5 i_mclk = ~i_mclk;

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
    endfunction
    function automatic logic [13:0] msk(input int r);
        return 14'h3fff >> (6 - 2 * r);
    endfunction
    function automatic logic [13:0] coded(input logic [13:0] w, input int r, input bit tw);
        logic [13:0] m;
        m = msk(r);
        return (w & m) ^ (tw ? (m ^ (m >> 1)) : 14'h0);
    endfunction

    task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_mclk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge i_mclk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        #1;
        rv = o_rdata;
    endtask
    task automatic mode(input bit se, input bit st, input logic [7:0] d, input bit e);
        @(posedge i_mclk);
        i_serial_enable <= se;
        i_clock_mode_strap <= st;
        wr(REG_DATA_CFG, d);
        repeat (6) @(posedge i_mclk);
        #1;
        chk("diff_clock", o_diff_clock_select, e);
    endtask
    task automatic xfer(input logic [13:0] w, input int r, input bit tw);
        logic [13:0] e;
        e = coded(w, r, tw);
        @(posedge i_mclk);
        ld <= 1'b1;
        wd <= w;
        @(posedge i_mclk);
        ld <= 1'b0;
        #1;
        lat = 0;
        while (o_code_valid !== 1'b1 && lat < 40) begin
            @(posedge i_mclk);
            #1;
            lat++;
        end
        chk("primary", o_primary_code, e);
        chk("complement", o_complement_code, ~e & msk(r));
    endtask
    task automatic close_out;
        $display("Checks %0d, mismatches %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge i_mclk);
        fails++;
        close_out();
    end

    initial begin
        {i_mclk, i_rst_n, i_clock_mode_strap, i_serial_enable, i_core_ready} = '0;
        {i_wr, i_rd, ld, i_addr, i_wdata, wd} = '0;
        fails = 0;
        checks = 0;
        seed = 32'h54821673;
        repeat (8) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        rd(REG_DATA_CFG);
        chk("data_cfg", rv, DATA_CFG_RST);
        rd(REG_RESOLUTION);
        chk("resolution", rv, 16'(RES_RST));
        rd(8'h55);
        chk("unmapped", rv, UNMAPPED_READ);
        $display("Test registers done");
        mode(0, 1, 8'h00, 1);
        mode(0, 0, 8'h04, 0);
        mode(1, 0, 8'h04, 1);
        mode(1, 1, 8'h00, 0);
        $display("Test clock mode done");
        @(posedge i_mclk);
        i_core_ready <= 1'b1;
        for (int r = 0; r < 4; r++) begin
            wr(REG_RESOLUTION, 8'(r));
            for (int t = 0; t < 2; t++) begin
                wr(REG_CODING, 8'(t));
                xfer(14'h3fff, r, t[0]);
                for (int k = 0; k < 3; k++) begin
                    seed = lfsr(seed);
                    xfer(seed[13:0], r, t[0]);
                end
            end
        end
        $display("Test coding done");
        wr(REG_CODING, 8'h00);
        xfer(14'h1234, 3, 0);
        l0 = lat;
        wr(REG_DATA_CFG, 8'h02);
        xfer(14'h2bcd, 3, 0);
        chk("deskew", 16'(lat - l0), 16'h1);
        wr(REG_DATA_CFG, 8'h00);
        $display("Test deskew done");
        i_core_ready <= 1'b0;
        for (int k = 0; k < 10; k++) begin
            @(posedge i_mclk);
            ld <= 1'b1;
            wd <= 14'(k + 16);
        end
        @(posedge i_mclk);
        ld <= 1'b0;
        repeat (6) @(posedge i_mclk);
        #1;
        chk("sample_ready", o_sample_ready, 1'b0);
        rd(REG_STATUS);
        chk("status", rv & 8'h06, 8'h06);
        @(posedge i_mclk);
        i_core_ready <= 1'b1;
        n = 0;
        repeat (30) begin
            @(posedge i_mclk);
            #1;
            if (o_code_valid === 1'b1) n++;
        end
        chk("drained", 16'(n), 16'h8);
        chk("sample_ready", o_sample_ready, 1'b1);
        wr(REG_STATUS, 8'h02);
        rd(REG_STATUS);
        chk("status_clear", rv, 8'h00);
        $display("Test fifo done");
        close_out();
    end
endmodule
